// >>> verilog/fbsd_status.sv
// Fieldbus slave diagnostic status encoder with Avalon-MM register access.
//
// Function
// - Run indicator dark in initialisation or firmware update state.
// - Run indicator blinks while pre-operational.
// - Single flash in safe-operational; outputs held in safe state.
// - Run indicator steadily lit when operational.
// - Green network indicator lit when online, dark when offline.
// - Green blinks after duplicate address check passes but master talk fails.
// - Red blinks on master communication error or timeout.
// - Red steady on bus-off, supply error, port error or failed address check.
// - Working counter bit 0 for valid data, 1 when host link failed.
// - State word low digit encodes host state 1,2,3,4,8.
// - State word bits flag slave, identity, init, absent and link errors.
// - Top four state word bits select port A through D.
// - Error count equals number of nodes with non-zero node state.
// - Diagnostic pending flag is 1 while unread diagnostics wait.
// - Node link code 0 ok, 1 deactivated, 2 missing, 18 ready.
// - Node link code 40 heartbeat missing, 41 shutdown received.
// - Electronic key mismatch codes 42 to 45.
// - Codes 46 startup fault, 47/48 data size, 49 idle.
// - Coupler code 00 run, 01 error, 80 idle, 08 diagnostics pending.
`timescale 1ns/10ps
module fbsd_status
   import fbsd_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             run_led,
   output logic             network_status_led_green,
   output logic             network_status_led_red,
   output logic             safe_outputs,
   output logic             working_counter_state,
   output logic [15:0]      state_word,
   output logic [7:0]       error_count,
   output logic             diag_pending_flag,
   output logic [7:0]       node_link_state,
   output logic [7:0]       io_coupler_state
);
   // =========================================================================
   // Declarations
   // =========================================================================
   fbsd_node_if nif ();

   logic [31:0]             host_q;
   logic [31:0]             net_q;
   logic [31:0]             link_q;
   logic [FBSD_NODE_AW-1:0] nodesel_q;
   logic                    cycle_q;
   logic                    ack_q;
   logic                    rd_pend_q;
   logic [31:0]             rdata_q;
   logic                    diag_q;
   logic [31:0]             blink_cnt_q;
   logic                    blink_q;
   logic [2:0]              phase_q;
   logic                    sflash_q;
   logic [FBSD_NODE_AW:0]   scan_q;
   logic [7:0]              cnt_acc_q;
   logic [7:0]              cnt_q;
   logic                    scan_vld_q;
   fbsd_host_st_t           hst_q;
   logic                    wr_hit;
   logic                    rd_hit;
   logic [31:0]             be_mask;

   // =========================================================================
   // Helper functions
   // =========================================================================
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   function automatic fbsd_host_st_t host_dec(input logic [2:0] sel);
      case (sel)
         3'h1:    host_dec = FBSD_HS_PRE;
         3'h2:    host_dec = FBSD_HS_BOOT;
         3'h3:    host_dec = FBSD_HS_SAFE;
         3'h4:    host_dec = FBSD_HS_OPER;
         default: host_dec = FBSD_HS_INIT;
      endcase
   endfunction

   // =========================================================================
   // Avalon-MM slave: one wait cycle, then the access completes.
   // =========================================================================
   assign wr_hit = avs_write & ~ack_q;
   assign rd_hit = avs_read & ~ack_q;

   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_be
         assign be_mask[gb*8 +: 8] = {8{avs_byteenable[gb]}};
      end
   endgenerate

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         host_q    <= FBSD_HOST_RST;
         net_q     <= FBSD_NET_RST;
         link_q    <= FBSD_LINK_RST;
         nodesel_q <= '0;
      end else if (wr_hit) begin
         case (avs_address)
            FBSD_ADDR_HOST:    host_q    <= merge(host_q, avs_writedata, be_mask);
            FBSD_ADDR_NET:     net_q     <= merge(net_q, avs_writedata, be_mask);
            FBSD_ADDR_LINK:    link_q    <= merge(link_q, avs_writedata, be_mask);
            FBSD_ADDR_NODESEL: nodesel_q <= avs_writedata[FBSD_NODE_AW-1:0];
            default: ;
         endcase
      end
   end

   // Cycle strobe latches the whole coded diagnostic output set at once.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cycle_q <= 1'b0;
      end else begin
         cycle_q <= wr_hit & (avs_address == FBSD_ADDR_CTRL) & avs_writedata[FBSD_CTRL_CYCLE];
      end
   end

   // Node state writes go straight into the memory.
   assign nif.we    = wr_hit & (avs_address == FBSD_ADDR_NODEST);
   assign nif.waddr = nodesel_q;
   assign nif.wdata = avs_writedata[7:0];
   assign nif.raddr = scan_q[FBSD_NODE_AW-1:0];

   fbsd_node_mem u_mem (
      .mclk (mclk),
      .nif  (nif)
   );

   // Read data are registered in the wait cycle and held through the acknowledge cycle.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rd_pend_q <= 1'b0;
         rdata_q   <= '0;
      end else begin
         rd_pend_q <= rd_hit;
         if (rd_hit) begin
            case (avs_address)
               FBSD_ADDR_HOST:    rdata_q <= host_q;
               FBSD_ADDR_NET:     rdata_q <= net_q;
               FBSD_ADDR_LINK:    rdata_q <= link_q;
               FBSD_ADDR_NODESEL: rdata_q <= {26'h0, nodesel_q};
               FBSD_ADDR_DIAG:    rdata_q <= {31'h0, diag_pending_flag};
               FBSD_ADDR_STATE:   rdata_q <= {15'h0, working_counter_state, state_word};
               FBSD_ADDR_COUNT:   rdata_q <= {24'h0, error_count};
               FBSD_ADDR_NODEOUT: rdata_q <= {16'h0, io_coupler_state, node_link_state};
               default:           rdata_q <= FBSD_UNMAPPED_RD;
            endcase
         end
      end
   end
   assign avs_readdata = rdata_q;

   // =========================================================================
   // Diagnostic pending flag; a new set wins over a simultaneous read ack.
   // =========================================================================
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         diag_q <= 1'b0;
      end else if (wr_hit && avs_address == FBSD_ADDR_CTRL && avs_writedata[FBSD_CTRL_DSET]) begin
         diag_q <= 1'b1;
      end else if (wr_hit && avs_address == FBSD_ADDR_CTRL && avs_writedata[FBSD_CTRL_DACK]) begin
         diag_q <= 1'b0;
      end
   end

   // =========================================================================
   // Blink generator: 200 ms phases; single flash is one lit phase in five.
   // =========================================================================
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b0;
         phase_q     <= '0;
         sflash_q    <= 1'b0;
      end else if (blink_cnt_q == 32'(FBSD_BLINK_CYC - 1)) begin
         blink_cnt_q <= '0;
         blink_q     <= ~blink_q;
         phase_q     <= (phase_q == 3'(FBSD_SFLASH_PH - 1)) ? 3'h0 : phase_q + 3'h1;
         sflash_q    <= (phase_q == 3'(FBSD_SFLASH_PH - 1));
      end else begin
         blink_cnt_q <= blink_cnt_q + 32'h1;
      end
   end

   // =========================================================================
   // Host side state machine follows the software selection.
   // =========================================================================
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         hst_q <= FBSD_HS_INIT;
      end else begin
         hst_q <= host_dec(host_q[2:0]);
      end
   end

   // Indicators are not tied to the data cycle: they must show state while
   // the bus is idle, so they track every clock.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         run_led      <= 1'b0;
         safe_outputs <= 1'b1;
      end else begin
         case (hst_q)
            FBSD_HS_INIT: run_led <= 1'b0;
            FBSD_HS_BOOT: run_led <= 1'b0;
            FBSD_HS_PRE:  run_led <= blink_q;
            FBSD_HS_SAFE: run_led <= sflash_q;
            FBSD_HS_OPER: run_led <= 1'b1;
            default:      run_led <= 1'b0;
         endcase
         safe_outputs <= (hst_q != FBSD_HS_OPER);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         network_status_led_green <= 1'b0;
         network_status_led_red   <= 1'b0;
      end else begin
         if (net_q[FBSD_NET_DUPOK] && (net_q[FBSD_NET_COMERR] || net_q[FBSD_NET_TMO])) begin
            network_status_led_green <= blink_q;
         end else begin
            network_status_led_green <= net_q[FBSD_NET_ONLINE];
         end
         if (net_q[FBSD_NET_BUSOFF] || net_q[FBSD_NET_VOLT] || net_q[FBSD_NET_PORTER] ||
             net_q[FBSD_NET_DUPBAD]) begin
            network_status_led_red <= 1'b1;
         end else begin
            network_status_led_red <= (net_q[FBSD_NET_COMERR] | net_q[FBSD_NET_TMO]) & blink_q;
         end
      end
   end

   // =========================================================================
   // Faulty node count: continuous scan of the node memory.
   // =========================================================================
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         scan_q     <= '0;
         scan_vld_q <= 1'b0;
         cnt_acc_q  <= '0;
         cnt_q      <= '0;
      end else begin
         scan_q     <= (scan_q == 7'(FBSD_NODES)) ? '0 : scan_q + 7'h1;
         scan_vld_q <= (scan_q != 7'(FBSD_NODES));
         if (scan_q == 7'(FBSD_NODES)) begin
            cnt_q     <= cnt_acc_q + 8'(scan_vld_q && nif.rdata != 8'h00);
            cnt_acc_q <= '0;
         end else if (scan_vld_q && nif.rdata != 8'h00) begin
            cnt_acc_q <= cnt_acc_q + 8'h1;
         end
      end
   end

   // =========================================================================
   // Coded diagnostic outputs, latched once per process data cycle.
   // =========================================================================
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         working_counter_state <= 1'b0;
         state_word            <= {12'h0, FBSD_ST_INIT};
         error_count           <= '0;
         diag_pending_flag     <= 1'b0;
         node_link_state       <= '0;
         io_coupler_state      <= FBSD_CPL_RUN;
      end else if (cycle_q) begin
         working_counter_state <= host_q[FBSD_HOST_WC_BIT];
         state_word[15:12] <= host_q[FBSD_HOST_PORT_LSB +: 4];
         state_word[11:4]  <= {host_q[FBSD_HOST_ERR_LSB + 6 -: 4], 1'b0,
                               host_q[FBSD_HOST_ERR_LSB +: 3]};
         case (hst_q)
            FBSD_HS_PRE:  state_word[3:0] <= FBSD_ST_PRE;
            FBSD_HS_BOOT: state_word[3:0] <= FBSD_ST_BOOT;
            FBSD_HS_SAFE: state_word[3:0] <= FBSD_ST_SAFE;
            FBSD_HS_OPER: state_word[3:0] <= FBSD_ST_OPER;
            default:      state_word[3:0] <= FBSD_ST_INIT;
         endcase
         error_count       <= cnt_q;
         diag_pending_flag <= diag_q;
         // Software writes the 6-bit code directly; values 0..2, 18, 40..49.
         node_link_state <= {2'b00, link_q[5:0]};
         if (link_q[FBSD_LINK_IDLE]) begin
            io_coupler_state <= FBSD_CPL_IDLE;
         end else if (link_q[FBSD_LINK_IOERR]) begin
            io_coupler_state <= FBSD_CPL_IOERR;
         end else if (link_q[FBSD_LINK_MDIAG] && link_q[FBSD_LINK_MDEN]) begin
            io_coupler_state <= FBSD_CPL_MDIAG;
         end else begin
            io_coupler_state <= FBSD_CPL_RUN;
         end
      end
   end
endmodule

// >>> verilog/fbsd_pkg.sv
// Package of constants and types for the fieldbus slave diagnostic status encoder.
package fbsd_pkg;
   // ==========================================================================
   // Avalon-MM register map (byte addresses, one word each)
   // ==========================================================================
   localparam logic [7:0] FBSD_ADDR_CTRL     = 8'h00;
   localparam logic [7:0] FBSD_ADDR_HOST     = 8'h04;
   localparam logic [7:0] FBSD_ADDR_NET      = 8'h08;
   localparam logic [7:0] FBSD_ADDR_LINK     = 8'h0c;
   localparam logic [7:0] FBSD_ADDR_NODESEL  = 8'h10;
   localparam logic [7:0] FBSD_ADDR_NODEST   = 8'h14;
   localparam logic [7:0] FBSD_ADDR_DIAG     = 8'h18;
   localparam logic [7:0] FBSD_ADDR_STATE    = 8'h1c;
   localparam logic [7:0] FBSD_ADDR_COUNT    = 8'h20;
   localparam logic [7:0] FBSD_ADDR_NODEOUT  = 8'h24;
   localparam logic [31:0] FBSD_UNMAPPED_RD  = 32'h0000_0000;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   // Host register: [2:0] host state select, [3] slave error, [4] bad identity,
   // [5] init error, [6] absent, [7] link error, [8] missing link,
   // [9] unexpected link, [13:10] port A..D, [14] host link failed.
   localparam int FBSD_HOST_ERR_LSB  = 3;
   localparam int FBSD_HOST_PORT_LSB = 10;
   localparam int FBSD_HOST_WC_BIT   = 14;
   // Net register: [0] online, [1] dup check passed, [2] comm error,
   // [3] timeout, [4] bus off, [5] supply error, [6] port error, [7] dup failed.
   localparam int FBSD_NET_ONLINE = 0;
   localparam int FBSD_NET_DUPOK  = 1;
   localparam int FBSD_NET_COMERR = 2;
   localparam int FBSD_NET_TMO    = 3;
   localparam int FBSD_NET_BUSOFF = 4;
   localparam int FBSD_NET_VOLT   = 5;
   localparam int FBSD_NET_PORTER = 6;
   localparam int FBSD_NET_DUPBAD = 7;
   // Link register: [5:0] node link state, [8] io run error, [9] idle/fault,
   // [10] module diag pending, [11] module diag enabled.
   localparam int FBSD_LINK_IOERR = 8;
   localparam int FBSD_LINK_IDLE  = 9;
   localparam int FBSD_LINK_MDIAG = 10;
   localparam int FBSD_LINK_MDEN  = 11;
   // Ctrl register: [0] cycle strobe (write 1 to latch outputs), [1] diag set,
   // [2] diag read acknowledge.
   localparam int FBSD_CTRL_CYCLE = 0;
   localparam int FBSD_CTRL_DSET  = 1;
   localparam int FBSD_CTRL_DACK  = 2;

   // ==========================================================================
   // Sizes, reset values and codes
   // ==========================================================================
   localparam int FBSD_NODES    = 64;
   localparam int FBSD_NODE_AW  = 6;
   localparam logic [31:0] FBSD_HOST_RST = 32'h0000_0000;
   localparam logic [31:0] FBSD_NET_RST  = 32'h0000_0000;
   localparam logic [31:0] FBSD_LINK_RST = 32'h0000_0000;

   localparam logic [3:0] FBSD_ST_INIT = 4'h1;
   localparam logic [3:0] FBSD_ST_PRE  = 4'h2;
   localparam logic [3:0] FBSD_ST_BOOT = 4'h3;
   localparam logic [3:0] FBSD_ST_SAFE = 4'h4;
   localparam logic [3:0] FBSD_ST_OPER = 4'h8;

   localparam logic [5:0] FBSD_NL_OK      = 6'h00;
   localparam logic [5:0] FBSD_NL_DEACT   = 6'h01;
   localparam logic [5:0] FBSD_NL_MISSING = 6'h02;
   localparam logic [5:0] FBSD_NL_READY   = 6'h12;
   localparam logic [5:0] FBSD_NL_HBEAT   = 6'h28;
   localparam logic [5:0] FBSD_NL_SHUT    = 6'h29;
   localparam logic [5:0] FBSD_NL_KVEND   = 6'h2a;
   localparam logic [5:0] FBSD_NL_KTYPE   = 6'h2b;
   localparam logic [5:0] FBSD_NL_KPROD   = 6'h2c;
   localparam logic [5:0] FBSD_NL_KREV    = 6'h2d;
   localparam logic [5:0] FBSD_NL_STARTUP = 6'h2e;
   localparam logic [5:0] FBSD_NL_PSIZE   = 6'h2f;
   localparam logic [5:0] FBSD_NL_CSIZE   = 6'h30;
   localparam logic [5:0] FBSD_NL_IDLE    = 6'h31;

   localparam logic [7:0] FBSD_CPL_RUN   = 8'h00;
   localparam logic [7:0] FBSD_CPL_IOERR = 8'h01;
   localparam logic [7:0] FBSD_CPL_MDIAG = 8'h08;
   localparam logic [7:0] FBSD_CPL_IDLE  = 8'h80;

   // Blink timing: 200 ms flashing phase, 1000 ms single flash period.
   localparam int FBSD_CLK_HZ     = 50_000_000;
   localparam int FBSD_BLINK_MS   = 200;
   localparam int FBSD_SFLASH_MS  = 1000;
   localparam int FBSD_BLINK_CYC  = FBSD_CLK_HZ / 1000 * FBSD_BLINK_MS;
   localparam int FBSD_SFLASH_PH  = FBSD_SFLASH_MS / FBSD_BLINK_MS;

   // Host state select codes, one-hot host side state machine.
   typedef enum logic [4:0] {
      FBSD_HS_INIT = 5'b00001,
      FBSD_HS_PRE  = 5'b00010,
      FBSD_HS_BOOT = 5'b00100,
      FBSD_HS_SAFE = 5'b01000,
      FBSD_HS_OPER = 5'b10000
   } fbsd_host_st_t;
endpackage

// >>> verilog/fbsd_node_if.sv
// Interface between the encoder and its node state memory.
`timescale 1ns/10ps
interface fbsd_node_if;
   import fbsd_pkg::*;
   logic                    we;
   logic [FBSD_NODE_AW-1:0] waddr;
   logic [7:0]              wdata;
   logic [FBSD_NODE_AW-1:0] raddr;
   logic [7:0]              rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// >>> verilog/fbsd_node_mem.sv
// Node state memory with registered read data.
`timescale 1ns/10ps
module fbsd_node_mem
   import fbsd_pkg::*;
(
   input wire logic mclk,
   fbsd_node_if.mem nif
);
   logic [7:0] mem_q [FBSD_NODES];
   logic [7:0] rdata_q;

   always_ff @(posedge mclk) begin
      if (nif.we) begin
         mem_q[nif.waddr] <= nif.wdata;
      end
      rdata_q <= mem_q[nif.raddr];
   end
   assign nif.rdata = rdata_q;
endmodule

// >>> verif/fbsd_status_sva.sv
// Concurrent checks on the ports of the diagnostic status encoder.
`timescale 1ns/10ps
module fbsd_status_sva
   import fbsd_pkg::*;
(
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   input wire logic [15:0] state_word,
   input wire logic [7:0]  error_count,
   input wire logic [7:0]  node_link_state,
   input wire logic [7:0]  io_coupler_state
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // ==========================================================================
   // Strobe age
   // ==========================================================================
   // Saturates so a long quiet spell cannot wrap back into the allowed window.
   logic [3:0] since_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) since_q <= 4'hf;
      else if (avs_write && avs_address == FBSD_ADDR_CTRL && avs_writedata[FBSD_CTRL_CYCLE]) since_q <= 4'h0;
      else if (since_q != 4'hf) since_q <= since_q + 4'h1;
   end
   // ==========================================================================
   // Properties
   // ==========================================================================
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
   property p_wait_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
   property p_state_code; state_word[3:0] inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8}; endproperty
   a_state_code: assert property (p_state_code) else $error("bad host state digit");
   property p_count; error_count <= 8'h40; endproperty
   a_count: assert property (p_count) else $error("error count above node total");
   property p_link; node_link_state[7:6] == 2'h0; endproperty
   a_link: assert property (p_link) else $error("node link code out of range");
   property p_coupler; io_coupler_state inside {8'h00, 8'h01, 8'h08, 8'h80}; endproperty
   a_coupler: assert property (p_coupler) else $error("bad coupler code");
   property p_sw_hold; $changed(state_word) |-> since_q < 4'h7; endproperty
   a_sw_hold: assert property (p_sw_hold) else $error("state word moved without strobe");
   property p_out_hold; $changed({error_count, node_link_state, io_coupler_state}) |-> since_q < 4'h7; endproperty
   a_out_hold: assert property (p_out_hold) else $error("diagnostics moved without strobe");
endmodule
bind fbsd_status fbsd_status_sva fbsd_status_sva_inst (.mclk, .nrst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_waitrequest, .state_word, .error_count, .node_link_state, .io_coupler_state);

// >>> verif/fbsd_host.sv
// Avalon-MM host model standing for the software side that writes the encoder registers.
`timescale 1ns/10ps
module fbsd_host (
   input  wire logic        mclk,
   input  wire logic        avs_waitrequest,
   input  wire logic [31:0] avs_readdata,
   output logic [7:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   output logic [3:0]       avs_byteenable,
   output logic             hang
);
   initial begin
      {avs_read, avs_write, hang} = 3'h0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
   end
   // Waitrequest and read data are taken at the rising edge that completes the access.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      bit done;
      done = 1'b0;
      @(posedge mclk);
      avs_read <= !wr;
      avs_write <= wr;
      avs_address <= a;
      avs_writedata <= d;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge mclk);
         done = !avs_waitrequest;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (!done) hang <= 1'b1;
   endtask
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the fieldbus slave diagnostic status encoder.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module testbench import fbsd_pkg::*; ;
   logic        mclk, nrst, avs_read, avs_write, avs_waitrequest, hang, run_led, safe_outputs;
   logic        network_status_led_green, network_status_led_red, working_counter_state, diag_pending_flag;
   logic [3:0]  avs_byteenable;
   logic [7:0]  avs_address, error_count, node_link_state, io_coupler_state;
   logic [15:0] state_word;
   logic [31:0] avs_writedata, avs_readdata, q;
   int          num_errors = 0;
   int          tests_run = 0;
   fbsd_status fbsd_status_inst (.mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .run_led, .network_status_led_green,
      .network_status_led_red, .safe_outputs, .working_counter_state, .state_word, .error_count,
      .diag_pending_flag, .node_link_state, .io_coupler_state);
   fbsd_host fbsd_host_inst (.mclk, .avs_waitrequest, .avs_readdata, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .hang);
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      fbsd_host_inst.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a);
      fbsd_host_inst.xfer(1'b0, a, 32'h0, q);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   // Outputs latch two edges after the strobe lands; four edges leaves margin.
   task automatic strobe;
      wr(FBSD_ADDR_CTRL, 32'h1);
      settle(4);
   endtask
   task automatic t_host_states;
      logic [3:0] code [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
      for (int s = 0; s < 5; s++) begin
         wr(FBSD_ADDR_HOST, 32'(s));
         strobe();
         `CHK(state_word[3:0], code[s])
         `CHK(safe_outputs, s != 4)
         if (s % 2 == 0) `CHK(run_led, s == 4)
      end
   endtask
   task automatic t_reset;
      @(posedge mclk);
      nrst <= 1'b0;
      settle(1);
      `CHK(state_word, 16'h0001)
      `CHK(run_led, 1'b0)
      `CHK(safe_outputs, 1'b1)
      @(posedge mclk);
      nrst <= 1'b1;
   endtask
   task automatic t_host_bits;
      logic [31:0] hv [2] = '{32'h16ac, 32'h6954};
      logic [15:0] sw [2] = '{16'h5a58, 16'ha528};
      for (int i = 0; i < 2; i++) begin
         wr(FBSD_ADDR_HOST, hv[i]);
         if (i == 1) `CHK(state_word, sw[0])
         strobe();
         `CHK(state_word, sw[i])
         `CHK(working_counter_state, i[0])
         rd(FBSD_ADDR_STATE);
         `CHK(q, {15'h0, i[0], sw[i]})
      end
   endtask
   task automatic t_net;
      logic [7:0] nv [6] = '{8'h00, 8'h01, 8'h11, 8'h21, 8'h41, 8'h80};
      logic [1:0] gr [6] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h3, 2'h1};
      for (int i = 0; i < 6; i++) begin
         wr(FBSD_ADDR_NET, {24'h0, nv[i]});
         settle(4);
         `CHK(network_status_led_green, gr[i][1])
         `CHK(network_status_led_red, gr[i][0])
      end
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40);
      `CHK(q, FBSD_UNMAPPED_RD)
      rd(FBSD_ADDR_NET);
      `CHK(q, 32'h80)
   endtask
   task automatic t_link;
      logic [5:0]  nl [14] = '{6'h00, 6'h01, 6'h02, 6'h12, 6'h28, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d,
                              6'h2e, 6'h2f, 6'h30, 6'h31};
      logic [11:0] lv [7] = '{12'h000, 12'h100, 12'h200, 12'h300, 12'h400, 12'hc00, 12'hd00};
      logic [7:0]  cv [7] = '{8'h00, 8'h01, 8'h80, 8'h80, 8'h00, 8'h08, 8'h01};
      for (int i = 0; i < 14; i++) begin
         wr(FBSD_ADDR_LINK, {26'h0, nl[i]});
         strobe();
         `CHK(node_link_state, {2'h0, nl[i]})
      end
      for (int i = 0; i < 7; i++) begin
         wr(FBSD_ADDR_LINK, {20'h0, lv[i]});
         strobe();
         `CHK(io_coupler_state, cv[i])
      end
      rd(FBSD_ADDR_NODEOUT);
      `CHK(q, 32'h0100)
   endtask
   task automatic t_nodes;
      for (int n = 0; n < 64; n++) begin
         wr(FBSD_ADDR_NODESEL, 32'(n));
         wr(FBSD_ADDR_NODEST, 32'h0);
      end
      settle(140);
      strobe();
      `CHK(error_count, 8'h00)
      for (int n = 0; n < 64; n += 21) begin
         wr(FBSD_ADDR_NODESEL, 32'(n));
         wr(FBSD_ADDR_NODEST, 32'h80);
      end
      settle(140);
      strobe();
      rd(FBSD_ADDR_COUNT);
      `CHK(q, 32'h4)
   endtask
   task automatic t_diag;
      logic [31:0] cmd [3] = '{32'h2, 32'h4, 32'h6};
      for (int i = 0; i < 3; i++) begin
         wr(FBSD_ADDR_CTRL, cmd[i]);
         settle(4);
         `CHK(diag_pending_flag, i[0])
         strobe();
         `CHK(diag_pending_flag, !i[0])
      end
      rd(FBSD_ADDR_DIAG);
      `CHK(q, 32'h1)
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   always @(posedge hang) begin
      num_errors++;
      tally_and_finish();
   end
   initial begin
      nrst = 1'b0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      // Node memory powers up unknown, so it is filled before any strobe latches the count.
      t_nodes();
      t_host_states();
      t_reset();
      t_host_bits();
      t_net();
      t_link();
      t_diag();
      tally_and_finish();
   end
endmodule
